// ===== hdl/level_pkg.sv
// constants, register map and state types of the fluid level sequencer
// Function
// - At power-up a measurement starts only if the start pin reads low.
// - Once started, the start pin is held low and ramp timing begins.
// - Probe current is enabled 25 ms after the cycle begins.
// - Lamp switches on together with probe current.
// - At 35 ms a sample-and-hold strobe captures initial probe voltage.
// - 1.5 s after the sample the comparator verdict is evaluated.
// - Verdict below reference turns lamp off, else lamp flashes at 1-2 Hz.
// - The result latch is loaded 10 ms after evaluation.
// - Probe current is switched off 8 ms after the latch, ending the cycle.
// - No further measurement until supply is removed and reapplied.
// - After the cycle, the lamp follows only the latched result.
// - Start pin not low at power-up: skip, lamp follows retained memory.
// - Memory flag is driven high when a measurement passes.
// - At power-up memory is refreshed high only if still above 3 V.
// - A failed measurement releases the memory flag, never drives it low.
// - With flashing disabled, a warning lights the lamp continuously.
// - Lamp lit during measurement, flashing afterwards while result fails.
// - Probe below 0.7 V flags short, above 5 V flags open.
package level_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
  // sequence times in ms, counted from the cycle start or the previous step
  localparam int T_CUR_MS = 25;
  localparam int T_SAMPLE_MS = 35;
  localparam int T_EVAL_MS = 1500;
  localparam int T_LATCH_MS = 10;
  localparam int T_OFF_MS = 8;
  // flash rate in tenths of a hertz, midway in the 1 Hz to 2 Hz band
  localparam int FLASH_DHZ = 15;
  localparam int FLASH_HALF_MS = (MS_PER_S * 10) / (2 * FLASH_DHZ);
  localparam int MS_W = 11;
  localparam int TB_W = 16;
  localparam int FL_W = 9;
  // synchroniser lanes and settling cycles before the start pin is trusted
  localparam int IN_START = 0;
  localparam int IN_CMP = 1;
  localparam int IN_SHORT = 2;
  localparam int IN_OPEN = 3;
  localparam int IN_MEM = 4;
  localparam int SYNC_N = 5;
  localparam logic [1:0] BOOT_WAIT = 2'h3;
  // register port
  localparam int ADDR_W = 2;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] REG_CTRL = 2'h0;
  localparam logic [ADDR_W-1:0] REG_TBDIV = 2'h1;
  localparam logic [ADDR_W-1:0] REG_STATUS = 2'h2;
  localparam int CTRL_FLASH_OFF = 0;
  localparam logic CTRL_FLASH_OFF_RST = 1'h0;
  localparam int ST_MEASURING = 0;
  localparam int ST_DONE = 1;
  localparam int ST_SKIPPED = 2;
  localparam int ST_FAIL = 3;
  localparam int ST_SHORT = 4;
  localparam int ST_OPEN = 5;
  localparam int ST_MEM = 6;
  localparam int ST_LAMP = 7;
  typedef enum logic [2:0] {
    st_boot, st_settle, st_heat, st_measure, st_hold, st_cool, st_done, st_skip
  } seq_state_t;
endpackage : level_pkg

// ===== hdl/ms_timebase.sv
// millisecond tick divider with programmable period
`timescale 1ns/100ps
module ms_timebase #(
  parameter int W = level_pkg::TB_W
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic run,
  input wire logic [W-1:0] div,
  output logic tick
);
  import level_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } tb_state_t;

  tb_state_t s, next;

  // a one-bit divider cannot hold the period of any useful clock
  if (W < 2) begin : g_check
    $error("timebase divider width too small");
  end

  // held at zero while stopped so the first tick lands one full period after start
  always_comb begin
    next = s;
    next.tick = 1'b0;
    if (!run) begin
      next.cnt = '0;
    end else if (s.cnt >= div) begin
      next.cnt = '0;
      next.tick = 1'b1;
    end else begin
      next.cnt = s.cnt + W'(1);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next;
    end
  end

  assign tick = s.tick;
endmodule : ms_timebase

// ===== hdl/lamp_flasher.sv
// square wave for the warning lamp, clocked by millisecond ticks
`timescale 1ns/100ps
module lamp_flasher #(
  parameter int W = level_pkg::FL_W,
  parameter int HALF = level_pkg::FLASH_HALF_MS
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic tick,
  input wire logic enable,
  output logic phase
);
  import level_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic phase;
  } fl_state_t;

  fl_state_t s, next;

  if (HALF < 1 || HALF >= 2 ** W) begin : g_check
    $error("flash half period does not fit its counter");
  end

  // restarts lit, so a new warning shows at once rather than after a dark half
  always_comb begin
    next = s;
    if (!enable) begin
      next.cnt = '0;
      next.phase = 1'b1;
    end else if (tick) begin
      if (s.cnt == W'(HALF - 1)) begin
        next.cnt = '0;
        next.phase = !s.phase;
      end else begin
        next.cnt = s.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next;
    end
  end

  assign phase = s.phase;
endmodule : lamp_flasher

// ===== hdl/fluid_level_measure_sequencer.sv
// single-shot thermal probe measurement sequencer with lamp and memory flag
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module fluid_level_measure_sequencer #(
  parameter int MS_CYCLES = level_pkg::MS_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic reset,
  // register port
  input wire logic [level_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [level_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [level_pkg::DATA_W-1:0] reg_rdata,
  // start control pin, two-way
  input wire logic start_n_in,
  output logic start_n_out,
  output logic start_n_oe,
  // analog front end verdicts
  input wire logic comparator_high,
  input wire logic probe_short,
  input wire logic probe_open,
  // retained memory flag pin, two-way
  input wire logic memory_level_ok,
  output logic memory_out,
  output logic memory_oe,
  // probe and lamp drive
  output logic probe_current_en,
  output logic sample_hold,
  output logic lamp_on
);
  import level_pkg::*;

  if (MS_CYCLES < 2 || MS_CYCLES > 2 ** TB_W) begin : g_check
    $error("MS_CYCLES outside the timebase divider range");
  end

  localparam logic [TB_W-1:0] TBDIV_RST = TB_W'(MS_CYCLES - 1);

  // last tick index of each step, counted from the step's own start
  localparam logic [MS_W-1:0] W_CUR = MS_W'(T_CUR_MS - 1);
  localparam logic [MS_W-1:0] W_SAMPLE = MS_W'(T_SAMPLE_MS - T_CUR_MS - 1);
  localparam logic [MS_W-1:0] W_EVAL = MS_W'(T_EVAL_MS - 1);
  localparam logic [MS_W-1:0] W_LATCH = MS_W'(T_LATCH_MS - 1);
  localparam logic [MS_W-1:0] W_OFF = MS_W'(T_OFF_MS - 1);

  typedef struct packed {
    seq_state_t state;
    logic [SYNC_N-1:0] s1;
    logic [SYNC_N-1:0] s2;
    logic [1:0] boot_cnt;
    logic [MS_W-1:0] ms;
    logic flash_off;
    logic [TB_W-1:0] tb_div;
    logic [DATA_W-1:0] rdata;
    logic start_hold;
    logic cur_en;
    logic sample;
    logic lamp;
    logic mem_drive;
    logic eval_done;
    logic eval_fail;
    logic result_fail;
    logic short_f;
    logic open_f;
  } top_state_t;

  top_state_t s, next;

  logic tick;
  logic flash_phase;
  logic warn;
  logic show;
  logic in_cycle;
  logic probe_live;
  logic [SYNC_N-1:0] pins;
  logic [DATA_W-1:0] status;

  // every pin from outside enters through two flip-flops
  assign pins[IN_START] = start_n_in;
  assign pins[IN_CMP] = comparator_high;
  assign pins[IN_SHORT] = probe_short;
  assign pins[IN_OPEN] = probe_open;
  assign pins[IN_MEM] = memory_level_ok;

  // timebase only runs once the power-up decision is made
  ms_timebase #(
    .W(TB_W)
  ) u_timebase (
    .clock(clock),
    .reset(reset),
    .run(s.state != st_boot),
    .div(s.tb_div),
    .tick(tick)
  );

  lamp_flasher #(
    .W(FL_W),
    .HALF(FLASH_HALF_MS)
  ) u_flasher (
    .clock(clock),
    .reset(reset),
    .tick(tick),
    .enable(warn && !s.flash_off),
    .phase(flash_phase)
  );

  // cycle phases as seen by status, lamp and fault logic
  assign in_cycle = (s.state == st_settle) || probe_live;
  assign probe_live = (s.state == st_heat) || (s.state == st_measure)
    || (s.state == st_hold) || (s.state == st_cool);

  // warning source: verdict and faults until the current stops, latch afterwards
  always_comb begin
    warn = 1'b0;
    unique case (s.state)
      st_boot, st_settle, st_heat, st_measure: warn = 1'b0;
      st_hold, st_cool: warn = s.eval_fail || s.short_f || s.open_f;
      st_done, st_skip: warn = s.result_fail;
    endcase
  end

  // continuous light when flashing is disabled
  assign show = s.flash_off ? 1'b1 : flash_phase;

  // status word for software
  always_comb begin
    status = '0;
    status[ST_MEASURING] = in_cycle;
    status[ST_DONE] = (s.state == st_done);
    status[ST_SKIPPED] = (s.state == st_skip);
    status[ST_FAIL] = s.result_fail;
    status[ST_SHORT] = s.short_f;
    status[ST_OPEN] = s.open_f;
    status[ST_MEM] = s.mem_drive;
    status[ST_LAMP] = s.lamp;
  end

  // sequencer, synchronisers, register port and output flops
  always_comb begin
    next = s;
    next.s1 = pins;
    next.s2 = s.s1;
    next.sample = 1'b0;
    next.rdata = '0;

    // millisecond counter of the current step
    if (tick) begin
      next.ms = s.ms + MS_W'(1);
    end

    unique case (s.state)
      // wait until the synchronised pins show their power-up level
      st_boot: begin
        next.ms = '0;
        if (s.boot_cnt != BOOT_WAIT) begin
          next.boot_cnt = s.boot_cnt + 2'h1;
        end else begin
          // refresh only a memory still above threshold, else cleared
          next.mem_drive = s.s2[IN_MEM];
          if (!s.s2[IN_START]) begin
            next.state = st_settle;
            next.start_hold = 1'b1;
          end else begin
            next.state = st_skip;
            next.result_fail = !s.s2[IN_MEM];
          end
        end
      end
      // let switch-on transients die before the probe is powered
      st_settle: begin
        if (tick && s.ms == W_CUR) begin
          next.state = st_heat;
          next.ms = '0;
          next.cur_en = 1'b1;
        end
      end
      st_heat: begin
        if (tick && s.ms == W_SAMPLE) begin
          next.state = st_measure;
          next.ms = '0;
          next.sample = 1'b1;
        end
      end
      // heating interval, then take the amplified difference verdict
      st_measure: begin
        if (tick && s.ms == W_EVAL) begin
          next.state = st_hold;
          next.ms = '0;
          next.eval_done = 1'b1;
          next.eval_fail = s.s2[IN_CMP];
        end
      end
      st_hold: begin
        if (tick && s.ms == W_LATCH) begin
          next.state = st_cool;
          next.ms = '0;
          next.result_fail = s.eval_fail || s.short_f || s.open_f;
          // a fail releases the pin; only an outside pull-down lowers it
          next.mem_drive = !(s.eval_fail || s.short_f || s.open_f);
        end
      end
      st_cool: begin
        if (tick && s.ms == W_OFF) begin
          next.state = st_done;
          next.ms = '0;
          next.cur_en = 1'b0;
        end
      end
      // terminal states: only a new power-up leaves them
      st_done, st_skip: begin
        next.ms = '0;
      end
    endcase

    // probe faults are sticky while current flows
    if (probe_live) begin
      if (s.s2[IN_SHORT]) begin
        next.short_f = 1'b1;
      end
      if (s.s2[IN_OPEN]) begin
        next.open_f = 1'b1;
      end
    end

    // lamp lit through measurement, then warning display or dark
    if (probe_live && !s.eval_done) begin
      next.lamp = 1'b1;
    end else if (warn) begin
      next.lamp = show;
    end else begin
      next.lamp = 1'b0;
    end
    // the step into heat lights the lamp in the same cycle as the current
    if (next.state == st_heat && s.state == st_settle) begin
      next.lamp = 1'b1;
    end

    // register writes; a zero divider would tick the timebase every clock, so floor at one
    if (reg_write) begin
      unique case (reg_addr)
        REG_CTRL: next.flash_off = reg_wdata[CTRL_FLASH_OFF];
        REG_TBDIV: begin
          if (reg_wdata == '0) begin
            next.tb_div = TB_W'(1);
          end else begin
            next.tb_div = reg_wdata;
          end
        end
        default: begin
        end
      endcase
    end

    // read data stand for the single cycle after the strobe
    if (reg_read) begin
      unique case (reg_addr)
        REG_CTRL: next.rdata[CTRL_FLASH_OFF] = s.flash_off;
        REG_TBDIV: next.rdata = s.tb_div;
        REG_STATUS: next.rdata = status;
        default: next.rdata = '0;
      endcase
    end
  end

  // single register stage for all state
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s.state <= st_boot;
      s.s1 <= '0;
      s.s2 <= '0;
      s.boot_cnt <= '0;
      s.ms <= '0;
      s.flash_off <= CTRL_FLASH_OFF_RST;
      s.tb_div <= TBDIV_RST;
      s.rdata <= '0;
      s.start_hold <= 1'b0;
      s.cur_en <= 1'b0;
      s.sample <= 1'b0;
      s.lamp <= 1'b0;
      s.mem_drive <= 1'b0;
      s.eval_done <= 1'b0;
      s.eval_fail <= 1'b0;
      s.result_fail <= 1'b0;
      s.short_f <= 1'b0;
      s.open_f <= 1'b0;
    end else begin
      s <= next;
    end
  end

  // outputs straight from flops, except start_n_out which is tied low
  assign reg_rdata = s.rdata;
  assign start_n_out = 1'b0;
  assign start_n_oe = s.start_hold;
  assign memory_out = s.mem_drive;
  assign memory_oe = s.mem_drive;
  assign probe_current_en = s.cur_en;
  assign sample_hold = s.sample;
  assign lamp_on = s.lamp;
endmodule : fluid_level_measure_sequencer

// ===== verif/level_seq_props.sv
// assertion checker bound to the level measurement sequencer ports
`timescale 1ns/100ps
module level_seq_props #(
  parameter int MS_CYCLES = 4
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic start_n_out,
  input wire logic start_n_oe,
  input wire logic memory_out,
  input wire logic memory_oe,
  input wire logic probe_current_en,
  input wire logic sample_hold,
  input wire logic lamp_on
);
  localparam int SAMP = 10 * MS_CYCLES;
  localparam int SPAN = 1528 * MS_CYCLES;
  localparam int LIT = 1510 * MS_CYCLES;
  logic [31:0] on_cnt;
  logic done_seen;
  // cycles since current came on; a counter avoids huge delay ranges at full rate
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      on_cnt <= '0;
      done_seen <= 1'b0;
    end else begin
      on_cnt <= probe_current_en ? on_cnt + 32'h1 : '0;
      if (!probe_current_en && on_cnt != '0) done_seen <= 1'b1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence cur_on;
    $rose(probe_current_en);
  endsequence
  sequence cur_off;
    $fell(probe_current_en);
  endsequence
  a_start_held: assert property (start_n_oe |=> start_n_oe)
    else $error("start pin released");
  a_start_low: assert property (start_n_oe |-> !start_n_out)
    else $error("start pin not pulled low");
  a_lamp_with_cur: assert property (cur_on |-> $rose(lamp_on))
    else $error("lamp not lit with current");
  a_sample_time: assert property (sample_hold |-> on_cnt >= SAMP - 1 && on_cnt <= SAMP + 1)
    else $error("sample strobe mistimed");
  a_sample_pulse: assert property (sample_hold |=> !sample_hold)
    else $error("sample strobe too long");
  a_cur_span: assert property (cur_off |-> on_cnt >= SPAN - 1 && on_cnt <= SPAN + 1)
    else $error("current span wrong");
  a_lamp_lit: assert property (probe_current_en && on_cnt < LIT - 2 |-> lamp_on)
    else $error("lamp dark while measuring");
  a_skip_idle: assert property (!start_n_oe |-> !probe_current_en)
    else $error("current without start");
  a_mem_no_low: assert property (memory_oe |-> memory_out)
    else $error("memory pin driven low");
  a_single_shot: assert property (done_seen |-> !probe_current_en)
    else $error("second measurement");
  a_pass_dark: assert property (done_seen && memory_oe |-> !lamp_on)
    else $error("lamp lit after pass");
endmodule : level_seq_props

// ===== verif/probe_front_model.sv
// behavioural thermal probe front end and pin levels facing the sequencer
`timescale 1ns/100ps
module probe_front_model (
  input wire logic probe_current_en,
  input wire logic sample_hold,
  input wire logic start_n_out,
  input wire logic start_n_oe,
  input wire logic ext_start_n,
  input wire logic fluid_low,
  input wire logic short_fault,
  input wire logic open_fault,
  input wire logic mem_charged,
  output logic start_n_in,
  output logic comparator_high,
  output logic probe_short,
  output logic probe_open,
  output logic memory_level_ok
);
  logic heated = 1'b0;
  // probe heats from the first sample until current stops
  always @(posedge sample_hold or negedge probe_current_en) heated <= sample_hold;
  // wired pin: device pull-down wins over the outside switch
  assign start_n_in = start_n_oe ? start_n_out : ext_start_n;
  // verdict settles once heated and holds through evaluation
  assign comparator_high = heated & fluid_low;
  // fault voltages only exist while current flows
  assign probe_short = probe_current_en & short_fault;
  assign probe_open = probe_current_en & open_fault;
  assign memory_level_ok = mem_charged;
endmodule : probe_front_model

// ===== verif/fluid_level_measure_sequencer_tb_top.sv
// testbench running repeated power-up measurements and skips
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module fluid_level_measure_sequencer_tb_top;
  import level_pkg::*;
  localparam int MS = 4;
  logic clock, reset, reg_write, reg_read, start_n_in, start_n_out, start_n_oe;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rv;
  logic comparator_high, probe_short, probe_open, memory_level_ok, memory_out, memory_oe;
  logic probe_current_en, sample_hold, lamp_on;
  logic ext_start_n, fluid_low, short_fault, open_fault, mem_charged;
  logic [6:0] cases [6] = '{7'h44, 7'h61, 7'h53, 7'h4d, 7'h04, 7'h01};
  int fail_count, checked, n;
  always #10 clock = ~clock;
  fluid_level_measure_sequencer #(.MS_CYCLES(MS)) dut_u (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .start_n_in(start_n_in), .start_n_out(start_n_out), .start_n_oe(start_n_oe),
    .comparator_high(comparator_high), .probe_short(probe_short), .probe_open(probe_open),
    .memory_level_ok(memory_level_ok), .memory_out(memory_out), .memory_oe(memory_oe),
    .probe_current_en(probe_current_en), .sample_hold(sample_hold), .lamp_on(lamp_on));
  probe_front_model probe_u (
    .probe_current_en(probe_current_en), .sample_hold(sample_hold),
    .start_n_out(start_n_out), .start_n_oe(start_n_oe), .ext_start_n(ext_start_n),
    .fluid_low(fluid_low), .short_fault(short_fault), .open_fault(open_fault),
    .mem_charged(mem_charged), .start_n_in(start_n_in), .comparator_high(comparator_high),
    .probe_short(probe_short), .probe_open(probe_open), .memory_level_ok(memory_level_ok));
  task end_of_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : reg_wr
  // read data is only valid in the cycle after the strobe
  task reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_rd
  // bounded wait; n holds the cycles spent
  task wait_cur(input logic lvl, input int lim);
    n = 0;
    while (probe_current_en !== lvl) begin
      @(posedge clock);
      #1 n++;
      if (n > lim) begin
        fail_count++;
        $display("wrong value at %0t: timeout", $time);
        end_of_test();
      end
    end
  endtask : wait_cur
  // one supply application: start, fluid, short, open, memory, steady lamp, fail
  task run(input logic [6:0] c);
    logic st, fl, sh, op, mem, fo, fail;
    {st, fl, sh, op, mem, fo, fail} = c;
    @(posedge clock);
    reset <= 1'b1;
    ext_start_n <= !st;
    fluid_low <= fl;
    short_fault <= sh;
    open_fault <= op;
    mem_charged <= mem;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    if (st) begin
      wait_cur(1'b1, 30 * MS);
      `CHK(n >= 25 * MS && n <= 25 * MS + 8, 1'b1)
      `CHK(lamp_on, 1'b1)
      `CHK(start_n_oe, 1'b1)
    end
    reg_rd(REG_TBDIV, rv);
    `CHK(rv, 16'(MS - 1))
    reg_rd(2'h3, rv);
    `CHK(rv, 16'h0000)
    reg_wr(REG_CTRL, {15'h0000, fo});
    reg_rd(REG_CTRL, rv);
    `CHK(rv, {15'h0000, fo})
    if (st) wait_cur(1'b0, 1540 * MS);
    else `CHK(start_n_oe, 1'b0)
    reg_rd(REG_STATUS, rv);
    `CHK(rv[5:2], {op & st, sh & st, fail, !st})
    `CHK(memory_oe, !fail)
    `CHK(lamp_on, fail)
    repeat (340 * MS) @(posedge clock);
    #1 `CHK(lamp_on, fail & fo)
    `CHK(probe_current_en, 1'b0)
  endtask : run
  // power cycles in sequence also exercise repeated strobing
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    ext_start_n = 1'b0;
    fluid_low = 1'b0;
    short_fault = 1'b0;
    open_fault = 1'b0;
    mem_charged = 1'b0;
    fail_count = 0;
    checked = 0;
    foreach (cases[i]) run(cases[i]);
    end_of_test();
  end
endmodule : fluid_level_measure_sequencer_tb_top
bind fluid_level_measure_sequencer level_seq_props #(.MS_CYCLES(MS_CYCLES)) props_u (
  .clock(clock), .reset(reset), .start_n_out(start_n_out), .start_n_oe(start_n_oe),
  .memory_out(memory_out), .memory_oe(memory_oe), .probe_current_en(probe_current_en),
  .sample_hold(sample_hold), .lamp_on(lamp_on));
